// File: core/ncs_sequencer.sv
// Charge-state sequencer for a series battery-pack charger.
`timescale 1ns/1ps

// Notes on behaviour
// RULE1: Charge starts at power-up with pack present or on later insertion.
// RULE2: Deglitched lockout holds reset, inhibits charge, clears timers; release goes presence.
// RULE3: Presence goes conditioning_phase when cell below detect level and temperature in window.
// RULE4: Conditioning_phase filters insertion noise for four seconds before removal may count.
// RULE5: Conditioning_phase selects the low regulation target.
// RULE6: Conditioning_phase goes fast-charge once cell exceeds low-cell level.
// RULE7: Conditioning_phase faults on thirty-minute timeout or over-temperature.
// RULE8: Cell above open level in conditioning_phase or fast-charge returns to presence.
// RULE9: Fast-charge selects high target and shows the charging LED pattern.
// RULE10: Fast-charge moves to finish phase on a temperature slope trip.
// RULE11: Slope trips are ignored for 4.3 minutes after fast-charge starts.
// RULE12: Fast-charge safety timer expiry moves to finish phase; duration external.
// RULE13: Over-temperature in fast-charge goes straight to done.
// RULE14: Finish phase restarts timer at half or quarter, low target, charging LED.
// RULE15: Finish phase goes done on timer expiry or over-temperature.
// RULE16: Done holds drive and LED off until removal, float, or discharge.
// RULE17: Fault holds drive off, pulses LED, leaves to presence on removal.
// RULE18: Floating timeout pin resets to presence and holds drive off; discharge unaffected.
// RULE19: Discharge-set trip enters discharge: drive low, sensing and LED disabled.
// RULE20: Discharge leaves to presence on discharge-clear or power cycle.
// RULE21: LED pulls low at 1 Hz while charging and 4 Hz in fault.
// RULE22: LED stays off with no cells present or discharge latched.
// RULE23: Fast-charge timer expiry clears the count before finish phase.
// RULE24: Mode input picks linear when low, comparator when high.
// RULE25: Comparator flags are synchronised; timers count clock cycles.
module ncs_sequencer #(
	parameter logic [47:0] FAST_CYC     = 48'(ncs_pkg::FAST_DEF_CYC),
	parameter logic [47:0] PRE_TO_CYC   = 48'(ncs_pkg::PRE_TIMEOUT_CYC),
	parameter logic [47:0] BLANK_CYC    = 48'(ncs_pkg::BLANK_CYC),
	parameter logic [47:0] FILTER_CYC   = 48'(ncs_pkg::INS_FILTER_CYC),
	parameter logic [47:0] SLOW_HALF    = 48'(ncs_pkg::SLOW_HALF_CYC),
	parameter logic [47:0] FAULT_HALF   = 48'(ncs_pkg::FAULT_HALF_CYC),
	parameter logic [47:0] DEGLITCH_CYC = 48'(ncs_pkg::DEGLITCH_CYC),
	parameter bit          REDUCED_FIN  = 1'b0
) (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       supply_lockout,
	input  wire logic       cell_open_in,
	input  wire logic       cell_detect_in,
	input  wire logic       low_cell_in,
	input  wire logic       temp_window_in,
	input  wire logic       over_temp_in,
	input  wire logic       slope_trip_in,
	input  wire logic       discharge_set_in,
	input  wire logic       discharge_clear_in,
	input  wire logic       timeout_float_in,
	input  wire logic       mode_comparator_in,
	input  wire logic [47:0] fast_timeout_cyc,
	output logic [1:0]      charge_target,
	output logic            charge_comparator_mode,
	output logic            charge_drive_out,
	output logic            charge_drive_oe_n,
	output logic            status_led_out,
	output logic            status_led_oe_n,
	output logic [3:0]      state_out
);

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	localparam int NIN = 11;
	// Lockout is bit 0 and resets asserted, so a just-released reset cannot look like a release.
	localparam logic [NIN-1:0] SYNC_RST = {{(NIN-1){1'b0}}, 1'b1};
	logic [NIN-1:0] raw_in;
	logic [NIN-1:0] s1_ff, s2_ff, s3_ff, flag_ff;
	logic [NIN-1:0] nxt_flag;
	assign raw_in = {mode_comparator_in, timeout_float_in, discharge_clear_in, discharge_set_in,
		slope_trip_in, over_temp_in, temp_window_in, low_cell_in, cell_detect_in,
		cell_open_in, supply_lockout};

	// A flag changes only when the second and third stages agree.
	always_comb
	begin
		for (int i = 0; i < NIN; i++)
			nxt_flag[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : flag_ff[i]; // see RULE25
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			s1_ff   <= SYNC_RST;
			s2_ff   <= SYNC_RST;
			s3_ff   <= SYNC_RST;
			flag_ff <= SYNC_RST; // see RULE2
		end
		else
		begin
			s1_ff   <= raw_in;
			s2_ff   <= s1_ff;
			s3_ff   <= s2_ff;
			flag_ff <= nxt_flag;
		end
	end

	logic f_lock, f_open, f_det, f_low, f_win, f_hot, f_slope, f_dset, f_dclr, f_float, f_mode;
	assign {f_mode, f_float, f_dclr, f_dset, f_slope, f_hot, f_win, f_low, f_det, f_open,
		f_lock} = flag_ff;

	// ****************************************************************
	// Lockout deglitch
	// ****************************************************************
	logic [47:0] dg_ff, nxt_dg;
	logic        lock_ff, nxt_lock;

	// The lockout must stand or clear for the full deglitch time to change.
	always_comb
	begin
		nxt_dg   = 48'h0;
		nxt_lock = lock_ff;
		if (f_lock != lock_ff)
		begin
			nxt_dg = dg_ff + 48'h1;
			if (nxt_dg >= DEGLITCH_CYC)
			begin
				nxt_lock = f_lock; // see RULE2
				nxt_dg   = 48'h0;
			end
		end
	end

	// Reset starts locked so power-up always passes through the reset state.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			dg_ff   <= 48'h0;
			lock_ff <= 1'b1;
		end
		else
		begin
			dg_ff   <= nxt_dg;
			lock_ff <= nxt_lock;
		end
	end

	// ****************************************************************
	// State machine and charge timers
	// ****************************************************************
	ncs_pkg::ncs_state_e st_ff, nxt_st;
	logic [47:0] tmr_ff, nxt_tmr;
	logic [47:0] fin_len;
	logic [47:0] fast_len;

	assign fast_len = (fast_timeout_cyc == 48'h0) ? FAST_CYC : fast_timeout_cyc;
	assign fin_len  = REDUCED_FIN ? (fast_len >> ncs_pkg::FINISH_CHARGE_PHASE_SHIFT_B)
		: (fast_len >> ncs_pkg::FINISH_CHARGE_PHASE_SHIFT);

	// One timer serves each phase; it restarts on every state change.
	always_comb
	begin
		nxt_st  = st_ff;
		nxt_tmr = tmr_ff + 48'h1;
		unique case (st_ff)
			ncs_pkg::ST_RESET:
				nxt_st = ncs_pkg::ST_PRESENCE; // see RULE2
			ncs_pkg::ST_PRESENCE:
				if (f_det && !f_open && f_win)
					nxt_st = ncs_pkg::ST_CONDITIONING_PHASE; // see RULE1 see RULE3
			ncs_pkg::ST_CONDITIONING_PHASE:
				if (f_hot || tmr_ff >= PRE_TO_CYC)
					nxt_st = ncs_pkg::ST_FAULT; // see RULE7
				else if (f_open)
				begin
					// A reading above the open level is noise or removal, never a charged cell.
					if (tmr_ff >= FILTER_CYC)
						nxt_st = ncs_pkg::ST_PRESENCE; // see RULE4 see RULE8
				end
				else if (f_low)
					nxt_st = ncs_pkg::ST_FAST; // see RULE6
			ncs_pkg::ST_FAST:
				if (f_hot)
					nxt_st = ncs_pkg::ST_DONE; // see RULE13
				else if (f_open)
					nxt_st = ncs_pkg::ST_PRESENCE; // see RULE8
				else if (tmr_ff >= fast_len)
					nxt_st = ncs_pkg::ST_FINISH; // see RULE12 see RULE23
				else if (f_slope && tmr_ff >= BLANK_CYC)
					nxt_st = ncs_pkg::ST_FINISH; // see RULE10 see RULE11
			ncs_pkg::ST_FINISH:
				if (f_hot || tmr_ff >= fin_len)
					nxt_st = ncs_pkg::ST_DONE; // see RULE15
			ncs_pkg::ST_DONE:
				if (f_open)
					nxt_st = ncs_pkg::ST_PRESENCE; // see RULE16
			ncs_pkg::ST_FAULT:
				if (f_open)
					nxt_st = ncs_pkg::ST_PRESENCE; // see RULE17
			ncs_pkg::ST_DISCHARGE:
				if (f_dclr)
					nxt_st = ncs_pkg::ST_PRESENCE; // see RULE20
			default:
				nxt_st = ncs_pkg::ST_RESET;
		endcase
		// Discharge detection overrides every charge state, float included.
		if (st_ff != ncs_pkg::ST_RESET && st_ff != ncs_pkg::ST_DISCHARGE && f_dset)
			nxt_st = ncs_pkg::ST_DISCHARGE; // see RULE19
		else if (f_float && st_ff != ncs_pkg::ST_DISCHARGE && st_ff != ncs_pkg::ST_RESET)
			nxt_st = ncs_pkg::ST_PRESENCE; // see RULE18 see RULE16
		if (lock_ff)
			nxt_st = ncs_pkg::ST_RESET; // see RULE2 see RULE20
		if (nxt_st != st_ff || lock_ff || (f_float && st_ff != ncs_pkg::ST_DISCHARGE))
			nxt_tmr = 48'h0; // see RULE14 see RULE23
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			st_ff  <= ncs_pkg::ST_RESET;
			tmr_ff <= 48'h0;
		end
		else
		begin
			st_ff  <= nxt_st;
			tmr_ff <= nxt_tmr;
		end
	end

	// ****************************************************************
	// Blink divider
	// ****************************************************************
	logic [47:0] blk_ff, nxt_blk;
	logic        phase_ff, nxt_phase;
	logic        charging, faulted;
	logic [47:0] half_len;

	assign charging = (st_ff == ncs_pkg::ST_CONDITIONING_PHASE) || (st_ff == ncs_pkg::ST_FAST)
		|| (st_ff == ncs_pkg::ST_FINISH);
	assign faulted  = (st_ff == ncs_pkg::ST_FAULT);
	assign half_len = faulted ? FAULT_HALF : SLOW_HALF;

	// Phase restarts whenever the pattern is off so each blink starts full length.
	always_comb
	begin
		nxt_blk   = blk_ff + 48'h1;
		nxt_phase = phase_ff;
		if (!(charging || faulted))
		begin
			nxt_blk   = 48'h0;
			nxt_phase = 1'b1;
		end
		else if (nxt_blk >= half_len)
		begin
			nxt_blk   = 48'h0;
			nxt_phase = ~phase_ff; // see RULE21
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			blk_ff   <= 48'h0;
			phase_ff <= 1'b1;
		end
		else
		begin
			blk_ff   <= nxt_blk;
			phase_ff <= nxt_phase;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Drive is released in idle states, pulled low in discharge, regulated when charging.
	always_comb
	begin
		charge_target = ncs_pkg::REG_OFF; // see RULE16 see RULE17
		if (st_ff == ncs_pkg::ST_DISCHARGE)
			charge_target = ncs_pkg::REG_ON; // see RULE19
		else if (f_float)
			charge_target = ncs_pkg::REG_OFF; // see RULE18
		else if (st_ff == ncs_pkg::ST_FAST)
			charge_target = ncs_pkg::REG_HIGH; // see RULE9
		else if (charging)
			charge_target = ncs_pkg::REG_LOW; // see RULE5 see RULE14
	end

	assign charge_comparator_mode = f_mode; // see RULE24
	assign charge_drive_out       = 1'b0;
	assign charge_drive_oe_n      = (charge_target != ncs_pkg::REG_ON);
	assign status_led_out         = 1'b0;
	assign status_led_oe_n        = ~((charging || faulted) && phase_ff); // see RULE22
	assign state_out              = st_ff;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	lock_holds_a: assert property (lock_ff |=> st_ff == ncs_pkg::ST_RESET && tmr_ff == 48'h0)
		else $error("Lockout did not hold reset."); // see RULE2
	reset_exit_a: assert property (st_ff == ncs_pkg::ST_RESET && !lock_ff && !f_dset
		|=> st_ff == ncs_pkg::ST_PRESENCE) else $error("Reset did not go to presence."); // see RULE2
	pre_target_a: assert property (st_ff == ncs_pkg::ST_CONDITIONING_PHASE && !f_float
		|-> charge_target == ncs_pkg::REG_LOW) else $error("Conditioning_phase target wrong."); // see RULE5
	pre_filter_a: assert property (st_ff == ncs_pkg::ST_CONDITIONING_PHASE && f_open && !f_hot
		&& tmr_ff < FILTER_CYC && tmr_ff < PRE_TO_CYC && !f_dset && !f_float && !lock_ff
		|=> st_ff == ncs_pkg::ST_CONDITIONING_PHASE) else $error("Insertion noise not filtered."); // see RULE4
	fast_target_a: assert property (st_ff == ncs_pkg::ST_FAST && !f_float
		|-> charge_target == ncs_pkg::REG_HIGH) else $error("Fast target wrong."); // see RULE9
	blank_hold_a: assert property (st_ff == ncs_pkg::ST_FAST && tmr_ff < BLANK_CYC && !f_hot
		&& !f_open && !f_dset && !f_float && !lock_ff && tmr_ff < fast_len
		|=> st_ff == ncs_pkg::ST_FAST) else $error("Slope trip not blanked."); // see RULE11
	hot_fast_a: assert property (st_ff == ncs_pkg::ST_FAST && f_hot && !f_dset && !f_float
		&& !lock_ff |=> st_ff == ncs_pkg::ST_DONE) else $error("Over-temp not done."); // see RULE13
	fault_exit_a: assert property (st_ff == ncs_pkg::ST_FAULT && f_open && !lock_ff && !f_dset
		|=> st_ff == ncs_pkg::ST_PRESENCE) else $error("Fault did not leave."); // see RULE17
	dis_drive_a: assert property (st_ff == ncs_pkg::ST_DISCHARGE
		|-> !charge_drive_oe_n && status_led_oe_n) else $error("Discharge outputs wrong."); // see RULE19
	led_idle_a: assert property (st_ff == ncs_pkg::ST_DONE || st_ff == ncs_pkg::ST_PRESENCE
		|-> status_led_oe_n) else $error("LED lit while idle."); // see RULE22
	timer_clr_a: assert property ($changed(st_ff) |-> tmr_ff == 48'h0)
		else $error("Timer not cleared on state change."); // see RULE23

endmodule : ncs_sequencer

// File: core/ncs_pkg.sv
// Constants and types shared by the charge-state sequencer.
package ncs_pkg;
	// ****************************************************************
	// Clock and timing constants
	// ****************************************************************
	localparam longint CLK_HZ          = 64'd200000000;
	localparam longint DEGLITCH_NS     = 64'd10000;
	localparam longint INS_FILTER_S    = 64'd4;
	localparam longint PRE_TIMEOUT_MIN = 64'd30;
	localparam longint BLANK_DMIN      = 64'd43;
	localparam longint FAST_MIN_DEF    = 64'd30;
	localparam longint DEGLITCH_CYC    = (DEGLITCH_NS * CLK_HZ) / 64'd1000000000;
	localparam longint INS_FILTER_CYC  = INS_FILTER_S * CLK_HZ;
	localparam longint PRE_TIMEOUT_CYC = PRE_TIMEOUT_MIN * 64'd60 * CLK_HZ;
	localparam longint BLANK_CYC       = BLANK_DMIN * 64'd6 * CLK_HZ;
	localparam longint FAST_DEF_CYC    = FAST_MIN_DEF * 64'd60 * CLK_HZ;
	localparam longint SLOW_BLINK_HZ   = 64'd1;
	localparam longint FAULT_BLINK_HZ  = 64'd4;
	localparam longint SLOW_HALF_CYC   = CLK_HZ / (SLOW_BLINK_HZ * 64'd2);
	localparam longint FAULT_HALF_CYC  = CLK_HZ / (FAULT_BLINK_HZ * 64'd2);
	localparam int     TMR_W           = 48;
	localparam int     FINISH_CHARGE_PHASE_SHIFT    = 1;
	localparam int     FINISH_CHARGE_PHASE_SHIFT_B  = 2;

	// ****************************************************************
	// Sequencer states, Gray coded along the charge path
	// ****************************************************************
	typedef enum logic [3:0] {
		ST_RESET     = 4'h0,
		ST_PRESENCE  = 4'h1,
		ST_CONDITIONING_PHASE = 4'h3,
		ST_FAST      = 4'h2,
		ST_FINISH    = 4'h6,
		ST_DONE      = 4'h7,
		ST_FAULT     = 4'h5,
		ST_DISCHARGE = 4'h4
	} ncs_state_e;

	// Regulation selection driven to the analog loop.
	typedef enum logic [1:0] {
		REG_OFF  = 2'h0,
		REG_LOW  = 2'h1,
		REG_HIGH = 2'h2,
		REG_ON   = 2'h3
	} ncs_reg_e;
endpackage : ncs_pkg

// File: verification/ncs_pack_model.sv
// Behavioural model of the cell pack and thermistor as seen through the comparators.
`timescale 1ns/1ps
module ncs_pack_model (
	input  wire logic [11:0] cell_mv,
	input  wire logic [7:0]  temp_c,
	output logic             cell_open_in,
	output logic             cell_detect_in,
	output logic             low_cell_in,
	output logic             temp_window_in,
	output logic             over_temp_in
);
	// Comparator decisions in millivolts per cell and degrees; a removed pack reads high.
	// Temperatures below freezing are not modelled, so the window has no lower test.
	assign cell_open_in   = cell_mv > 12'h672;
	assign cell_detect_in = cell_mv < 12'h60E;
	assign low_cell_in    = cell_mv > 12'h3E8;
	assign temp_window_in = temp_c <= 8'h2D;
	assign over_temp_in   = temp_c > 8'h32;
endmodule : ncs_pack_model

// File: verification/ncs_sequencer_tb.sv
// Self-checking testbench for the charge-state sequencer.
`timescale 1ns/1ps
module ncs_sequencer_tb;
	localparam int FAST = 32'h7D0;
	localparam int SLOW = 32'h14;
	localparam int FLT  = 32'h5;
	localparam int FTO  = 32'h5DC;
	logic [47:0] fast_timeout_cyc = 48'h0;
	logic        ref_clk = 1'b0, rst = 1'b1, supply_lockout = 1'b1;
	logic        slope_trip_in = 1'b0, timeout_float_in = 1'b0, mode_comparator_in = 1'b0;
	logic        discharge_set_in = 1'b0, discharge_clear_in = 1'b0;
	logic [11:0] cell_mv = 12'h708;
	logic [7:0]  temp_c = 8'h19;
	logic        cell_open_in, cell_detect_in, low_cell_in, temp_window_in, over_temp_in;
	logic [1:0]  charge_target;
	logic        charge_comparator_mode, charge_drive_out, charge_drive_oe_n;
	logic        status_led_out, status_led_oe_n;
	logic [3:0]  state_out;
	int          err_count = 0;
	int          cmp_count = 0;
	int          n;

	// ************************************************************
	// Clock, partner and device
	// ************************************************************
	// Free-running 200 MHz clock.
	always #2.5 ref_clk = ~ref_clk;

	ncs_pack_model PACK (.cell_mv(cell_mv), .temp_c(temp_c), .cell_open_in(cell_open_in),
		.cell_detect_in(cell_detect_in), .low_cell_in(low_cell_in),
		.temp_window_in(temp_window_in), .over_temp_in(over_temp_in));

	ncs_sequencer #(.FAST_CYC(48'(FAST)), .PRE_TO_CYC(48'h1F4), .BLANK_CYC(48'h64),
		.FILTER_CYC(48'h32), .SLOW_HALF(48'(SLOW)), .FAULT_HALF(48'(FLT)),
		.DEGLITCH_CYC(48'h4), .REDUCED_FIN(1'b0)) DUT (
		.ref_clk(ref_clk), .rst(rst), .supply_lockout(supply_lockout),
		.cell_open_in(cell_open_in), .cell_detect_in(cell_detect_in),
		.low_cell_in(low_cell_in), .temp_window_in(temp_window_in),
		.over_temp_in(over_temp_in), .slope_trip_in(slope_trip_in),
		.discharge_set_in(discharge_set_in), .discharge_clear_in(discharge_clear_in),
		.timeout_float_in(timeout_float_in), .mode_comparator_in(mode_comparator_in),
		.fast_timeout_cyc(fast_timeout_cyc), .charge_target(charge_target),
		.charge_comparator_mode(charge_comparator_mode), .charge_drive_out(charge_drive_out),
		.charge_drive_oe_n(charge_drive_oe_n), .status_led_out(status_led_out),
		.status_led_oe_n(status_led_oe_n), .state_out(state_out));

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic check(input bit ok, input string msg);
		cmp_count++;
		if (!ok)
		begin
			err_count++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask : check

	// Waits a bounded number of falling edges for a state; n keeps the wait.
	task automatic wait_state(input logic [3:0] s, input int lim);
		n = 0;
		while (state_out !== s && n < lim)
		begin
			@(negedge ref_clk);
			n++;
		end
		check(state_out === s, "state not reached");
	endtask : wait_state

	task automatic hold(input logic [3:0] s, input int cyc);
		bit ok;
		ok = 1'b1;
		repeat (cyc)
		begin
			@(negedge ref_clk);
			ok &= (state_out === s);
		end
		check(ok, "state left early");
	endtask : hold

	// Measures one full level of the LED, skipping the partial one in progress.
	task automatic led_half(input int exp);
		logic v;
		int   h;
		for (int k = 0; k < 2; k++)
		begin
			v = status_led_oe_n;
			h = 0;
			while (status_led_oe_n === v && h < 100)
			begin
				@(negedge ref_clk);
				h++;
			end
		end
		check(h >= exp - 1 && h <= exp + 1, "led half period");
	endtask : led_half

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop

	// Watchdog sized at several times the expected run of some 3500 cycles.
	initial
	begin
		#150000;
		err_count++;
		report_and_stop();
	end

	// ************************************************************
	// Test sequence
	// ************************************************************
	// Inputs change only at falling edges, away from the sampling edge.
	initial
	begin
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		check(state_out === 4'h0 && charge_drive_oe_n === 1'b1, "reset outputs");
		hold(4'h0, 20);
		supply_lockout = 1'b0;
		wait_state(4'h1, 30);
		check(status_led_oe_n === 1'b1, "led on with no cells");
		temp_c = 8'h37;
		cell_mv = 12'h320;
		hold(4'h1, 20);
		temp_c = 8'h19;
		wait_state(4'h3, 10);
		check(charge_target === ncs_pkg::REG_LOW, "conditioning_phase target");
		cell_mv = 12'h708;
		hold(4'h3, 10);
		cell_mv = 12'h320;
		wait_state(4'h5, 520);
		check(n >= 470, "conditioning_phase timeout early");
		check(charge_drive_oe_n === 1'b1 && charge_target === ncs_pkg::REG_OFF, "fault drive");
		led_half(FLT);
		cell_mv = 12'h708;
		wait_state(4'h1, 10);
		cell_mv = 12'h320;
		wait_state(4'h3, 10);
		temp_c = 8'h37;
		wait_state(4'h5, 10);
		temp_c = 8'h19;
		cell_mv = 12'h708;
		wait_state(4'h1, 10);
		cell_mv = 12'h4B0;
		wait_state(4'h2, 20);
		check(charge_target === ncs_pkg::REG_HIGH, "fast target");
		slope_trip_in = 1'b1;
		hold(4'h2, 80);
		wait_state(4'h6, 40);
		slope_trip_in = 1'b0;
		check(charge_target === ncs_pkg::REG_LOW, "finish target");
		led_half(SLOW);
		wait_state(4'h7, FAST / 2 + 10);
		check(n >= FAST / 2 - 60, "finish too short");
		check(charge_drive_oe_n === 1'b1 && status_led_oe_n === 1'b1, "done outputs");
		hold(4'h7, 20);
		timeout_float_in = 1'b1;
		wait_state(4'h1, 10);
		fast_timeout_cyc = 48'(FTO);
		timeout_float_in = 1'b0;
		wait_state(4'h2, 20);
		led_half(SLOW);
		wait_state(4'h6, FTO + 10);
		check(n >= FTO - 80, "fast timer early");
		fast_timeout_cyc = 48'h0;
		temp_c = 8'h37;
		wait_state(4'h7, 10);
		temp_c = 8'h19;
		cell_mv = 12'h708;
		wait_state(4'h1, 10);
		cell_mv = 12'h4B0;
		wait_state(4'h2, 20);
		temp_c = 8'h37;
		wait_state(4'h7, 10);
		temp_c = 8'h19;
		discharge_set_in = 1'b1;
		wait_state(4'h4, 10);
		discharge_set_in = 1'b0;
		check(charge_target === ncs_pkg::REG_ON && charge_drive_oe_n === 1'b0, "drive");
		check(charge_drive_out === 1'b0 && status_led_out === 1'b0, "pin level");
		check(status_led_oe_n === 1'b1, "led on in discharge");
		timeout_float_in = 1'b1;
		hold(4'h4, 10);
		timeout_float_in = 1'b0;
		discharge_clear_in = 1'b1;
		wait_state(4'h1, 10);
		discharge_clear_in = 1'b0;
		wait_state(4'h2, 20);
		cell_mv = 12'h708;
		wait_state(4'h1, 10);
		cell_mv = 12'h4B0;
		wait_state(4'h2, 20);
		timeout_float_in = 1'b1;
		wait_state(4'h1, 10);
		hold(4'h1, 10);
		check(charge_drive_oe_n === 1'b1, "drive during float");
		timeout_float_in = 1'b0;
		mode_comparator_in = 1'b1;
		repeat (8) @(negedge ref_clk);
		check(charge_comparator_mode === 1'b1, "mode flag");
		supply_lockout = 1'b1;
		wait_state(4'h0, 20);
		check(charge_target === ncs_pkg::REG_OFF, "lockout target");
		report_and_stop();
	end
endmodule : ncs_sequencer_tb
